// ===== hw/interval_timer_pkg.sv
// Constants shared by the interval timer channel logic.
// Assumes an 8-bit processor bus and three independent counters.
package interval_timer_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int NUM_COUNTERS = 3;
    localparam int SYNC_STAGES = 2;
    // Port addresses formed as {port_select_hi, port_select_lo}.
    localparam logic [1:0] PORT_CONTROL = 2'h3;
    // Control word fields.
    localparam int CW_SEL_HI = 7;
    localparam int CW_SEL_LO = 6;
    localparam int CW_FMT_HI = 5;
    localparam int CW_FMT_LO = 4;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] FMT_LATCH = 2'h0;
    localparam logic [1:0] FMT_LO_ONLY = 2'h1;
    localparam logic [1:0] FMT_HI_ONLY = 2'h2;
    localparam logic [1:0] FMT_BOTH = 2'h3;
    // Read-back command fields; count and status latch bits are active low.
    localparam int RB_COUNT_N = 5;
    localparam int RB_STATUS_N = 4;
    localparam int RB_SEL0 = 1;
    localparam int RB_ZERO = 0;
    // Status byte fields.
    localparam int ST_OUT = 7;
    localparam int ST_NULL = 6;
    // Effective counting modes.
    localparam logic [2:0] MODE_TERMINAL = 3'h0;
    localparam logic [2:0] MODE_ONESHOT = 3'h1;
    localparam logic [2:0] MODE_RATE = 3'h2;
    localparam logic [2:0] MODE_SQUARE = 3'h3;
    localparam logic [2:0] MODE_SW_STROBE = 3'h4;
    localparam logic [2:0] MODE_HW_STROBE = 3'h5;
    localparam logic [5:0] CTRL_RESET = 6'h00;
endpackage : interval_timer_pkg

// ===== hw/interval_timer.sv
// Three-channel programmable down-counting interval timer with latch and read-back.
// Assumes all processor pins, gates and count clocks are asynchronous to ref_clk_i.
`timescale 1ns/100ps

// Contract
// - Hardware-strobe output rests high, pulses low one count clock when count hits zero.
// - Hardware-strobe mode loads only on the clock after a trigger, without decrementing.
// - In one-shot, rate, square and hardware-strobe modes a gate trigger reloads the initial count at the next count clock.
// - In one-shot and hardware-strobe modes a new count waits for the next trigger before it is used.
// - In hardware-strobe mode the gate level never touches the output.
// - Rate and square modes: gate low inhibits and forces high; rising edge restarts.
// - Counters count down; square-wave mode steps by two.
// - Latch command copies the count, held until read or new control word.
// - A second latch command before the read is ignored.
// - Read and write byte order are tracked separately per counter.
// - Read-back bits 3..1 select counters 2..0; bit 0 is zero.
// - Read-back bit 5 low latches count, bit 4 low latches status.
// - Reading one latched counter releases only that counter's latch.
// - Later read-back commands on an unread counter are ignored.
// - A latched status byte is returned on the next data read.
// - Status holds output level, pending-load flag and the last control fields.
// - Pending-load flag is one until the written count reaches the counting element.
// - Control or count writes set the pending-load flag; the transfer clears it.
// - With both latched, status reads first, then the count.
// - A control word with both top bits one is a read-back command.
module interval_timer (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic port_select_lo_i,
    input wire logic port_select_hi_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    input wire logic [interval_timer_pkg::NUM_COUNTERS-1:0] count_clk_i,
    input wire logic [interval_timer_pkg::NUM_COUNTERS-1:0] gate_i,
    output logic [interval_timer_pkg::NUM_COUNTERS-1:0] out_o
);
    import interval_timer_pkg::*;

    localparam int SW = 19;

    // Reduces the mode codes of a control word to the effective mode; codes 6 and 7 alias 2 and 3.
    function automatic logic [2:0] eff_mode(input logic [5:0] ctrl);
        eff_mode = (ctrl[3] && !ctrl[2]) ? {1'b1, 1'b0, ctrl[1]} : {1'b0, ctrl[2:1]};
    endfunction : eff_mode

    // Picks the byte a read returns from a 16-bit value under the read format.
    function automatic logic [7:0] pick_byte(input logic [15:0] v, input logic [1:0] fmt,
                                             input logic msb);
        pick_byte = (fmt == FMT_HI_ONLY || (fmt == FMT_BOTH && msb)) ? v[15:8] : v[7:0];
    endfunction : pick_byte

    logic [SW-1:0] sync_meta;
    logic [SW-1:0] sync_q;
    logic [SW-1:0] sync_prev;
    logic cs_n_s;
    logic rd_n_s;
    logic wr_n_s;
    logic [1:0] addr_s;
    logic [7:0] data_s;
    logic [2:0] gate_s;
    logic [2:0] cclk_s;
    logic [2:0] gate_prev;
    logic [2:0] cclk_prev;

    assign {cs_n_s, rd_n_s, wr_n_s, addr_s, data_s, gate_s, cclk_s} = sync_q;
    assign gate_prev = sync_prev[5:3];
    assign cclk_prev = sync_prev[2:0];

    // Bus cycle tracking: address and data are captured while the strobe is low.
    logic wr_act;
    logic rd_act;
    logic wr_act_q;
    logic rd_act_q;
    logic [1:0] wr_addr;
    logic [7:0] wr_data;
    logic [1:0] rd_addr;
    wire write_stb = wr_act_q && !wr_act;
    wire read_stb = rd_act_q && !rd_act;
    wire ctl_write = write_stb && wr_addr == PORT_CONTROL;
    wire is_readback = wr_data[CW_SEL_HI:CW_SEL_LO] == SEL_READBACK;

    assign wr_act = !cs_n_s && !wr_n_s;
    assign rd_act = !cs_n_s && !rd_n_s;
    assign data_oe_o = rd_act && addr_s != PORT_CONTROL;

    // Per-counter state, one independent set for each channel.
    logic [5:0] ctrl [NUM_COUNTERS];
    logic [15:0] cr [NUM_COUNTERS];
    logic [7:0] cr_lo_stage [NUM_COUNTERS];
    logic [15:0] ce [NUM_COUNTERS];
    logic [15:0] read_latch [NUM_COUNTERS];
    logic [7:0] status_latch [NUM_COUNTERS];
    logic [2:0] count_latched;
    logic [2:0] status_latched;
    logic [2:0] null_count;
    logic [2:0] write_msb;
    logic [2:0] read_msb;
    logic [2:0] load_req;
    logic [2:0] trig;
    logic [2:0] running;
    logic [2:0] out;

    logic [2:0] cw_hit;
    logic [2:0] latch_cmd;
    logic [2:0] rb_count;
    logic [2:0] rb_status;
    logic [2:0] cnt_write;
    logic [2:0] cnt_read;
    logic [2:0] clk_fall;
    logic [2:0] gate_rise;
    logic [2:0] enabled;
    logic [2:0] trig_mode;
    logic [2:0] forced_high;
    logic [2:0] cnt_done;
    logic [7:0] status_now [NUM_COUNTERS];
    logic [7:0] rd_byte [NUM_COUNTERS];
    logic [2:0] mode [NUM_COUNTERS];

    for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_dec
        assign mode[i] = eff_mode(ctrl[i]);
        assign cw_hit[i] = ctl_write && !is_readback
            && wr_data[CW_SEL_HI:CW_SEL_LO] == 2'(i)
            && wr_data[CW_FMT_HI:CW_FMT_LO] != FMT_LATCH;
        assign latch_cmd[i] = ctl_write && !is_readback
            && wr_data[CW_SEL_HI:CW_SEL_LO] == 2'(i)
            && wr_data[CW_FMT_HI:CW_FMT_LO] == FMT_LATCH;
        assign rb_count[i] = ctl_write && is_readback && !wr_data[RB_ZERO]
            && wr_data[RB_SEL0+i] && !wr_data[RB_COUNT_N];
        assign rb_status[i] = ctl_write && is_readback && !wr_data[RB_ZERO]
            && wr_data[RB_SEL0+i] && !wr_data[RB_STATUS_N];
        assign cnt_write[i] = write_stb && wr_addr == 2'(i);
        assign cnt_read[i] = read_stb && rd_addr == 2'(i);
        assign clk_fall[i] = cclk_prev[i] && !cclk_s[i];
        assign gate_rise[i] = !gate_prev[i] && gate_s[i];
        assign trig_mode[i] = mode[i] == MODE_ONESHOT || mode[i] == MODE_HW_STROBE
            || mode[i] == MODE_RATE || mode[i] == MODE_SQUARE;
        // The one-shot and hardware strobe ignore the gate level entirely.
        assign enabled[i] = gate_s[i] || mode[i] == MODE_ONESHOT
            || mode[i] == MODE_HW_STROBE;
        assign forced_high[i] = !gate_s[i]
            && (mode[i] == MODE_RATE || mode[i] == MODE_SQUARE);
        assign cnt_done[i] = ctrl[i][5:4] != FMT_BOTH || write_msb[i];
        assign status_now[i] = {out[i], null_count[i], ctrl[i]};
        assign rd_byte[i] = status_latched[i] ? status_latch[i]
            : pick_byte(count_latched[i] ? read_latch[i] : ce[i], ctrl[i][5:4], read_msb[i]);
    end

    assign out_o = out;

    always_ff @(posedge ref_clk_i) begin
        sync_meta <= {cs_n_i, rd_n_i, wr_n_i, port_select_hi_i, port_select_lo_i, data_i,
                      gate_i, count_clk_i};
        sync_q <= sync_meta;
        sync_prev <= sync_q;
        wr_act_q <= wr_act;
        rd_act_q <= rd_act;
        if (wr_act) begin
            wr_addr <= addr_s;
            wr_data <= data_s;
        end
        if (rd_act) begin
            rd_addr <= addr_s;
        end
        data_o <= (addr_s == PORT_CONTROL) ? 8'h00 : rd_byte[addr_s];
        if (rst_i) begin
            sync_meta <= {3'h7, 2'h0, 8'h00, 3'h0, 3'h0};
            sync_q <= {3'h7, 2'h0, 8'h00, 3'h0, 3'h0};
            sync_prev <= {3'h7, 2'h0, 8'h00, 3'h0, 3'h0};
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
            wr_addr <= 2'h0;
            wr_data <= 8'h00;
            rd_addr <= 2'h0;
            data_o <= 8'h00;
        end
    end

    // Counting, loading, latching and read sequencing for every channel.
    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < NUM_COUNTERS; i++) begin
            if (gate_rise[i]) begin
                trig[i] <= 1'b1;
            end
            if (clk_fall[i]) begin
                trig[i] <= gate_rise[i];
                if (trig[i] && trig_mode[i]) begin
                    // Load on the clock after a trigger; this clock does not count.
                    ce[i] <= (mode[i] == MODE_SQUARE) ? {cr[i][15:1], 1'b0} : cr[i];
                    null_count[i] <= 1'b0;
                    running[i] <= 1'b1;
                    load_req[i] <= 1'b0;
                    out[i] <= mode[i] != MODE_ONESHOT;
                end else if (load_req[i]) begin
                    ce[i] <= (mode[i] == MODE_SQUARE) ? {cr[i][15:1], 1'b0} : cr[i];
                    null_count[i] <= 1'b0;
                    running[i] <= 1'b1;
                    load_req[i] <= 1'b0;
                end else if (running[i] && enabled[i]) begin
                    unique case (mode[i])
                        MODE_RATE: begin
                            ce[i] <= (ce[i] == 16'h0001) ? cr[i] : ce[i] - 16'h0001;
                            out[i] <= ce[i] != 16'h0002;
                            if (ce[i] == 16'h0001) begin
                                null_count[i] <= 1'b0;
                            end
                        end
                        MODE_SQUARE: begin
                            ce[i] <= (ce[i] == 16'h0002) ? {cr[i][15:1], 1'b0}
                                : ce[i] - 16'h0002;
                            if (ce[i] == 16'h0002) begin
                                out[i] <= !out[i];
                                null_count[i] <= 1'b0;
                            end
                        end
                        MODE_SW_STROBE, MODE_HW_STROBE: begin
                            ce[i] <= ce[i] - 16'h0001;
                            if (!out[i]) begin
                                out[i] <= 1'b1;
                                running[i] <= 1'b0;
                            end else if (ce[i] == 16'h0001) begin
                                out[i] <= 1'b0;
                            end
                        end
                        default: begin
                            ce[i] <= ce[i] - 16'h0001;
                            if (ce[i] == 16'h0001) begin
                                out[i] <= 1'b1;
                            end
                        end
                    endcase
                end
            end
            if (forced_high[i]) begin
                out[i] <= 1'b1;
            end
            // Count writes; the write pointer is separate from the read pointer.
            if (cnt_write[i]) begin
                write_msb[i] <= ctrl[i][5:4] == FMT_BOTH && !write_msb[i];
                if (!cnt_done[i]) begin
                    cr_lo_stage[i] <= wr_data;
                end else begin
                    unique case (ctrl[i][5:4])
                        FMT_LO_ONLY: cr[i] <= {8'h00, wr_data};
                        FMT_HI_ONLY: cr[i] <= {wr_data, 8'h00};
                        default: cr[i] <= {wr_data, cr_lo_stage[i]};
                    endcase
                    null_count[i] <= 1'b1;
                    if (mode[i] == MODE_TERMINAL || mode[i] == MODE_SW_STROBE
                        || (!running[i] && (mode[i] == MODE_RATE || mode[i] == MODE_SQUARE))) begin
                        load_req[i] <= 1'b1;
                    end
                    if (mode[i] == MODE_TERMINAL) begin
                        out[i] <= 1'b0;
                    end
                end
            end
            if (latch_cmd[i] || rb_count[i]) begin
                if (!count_latched[i]) begin
                    read_latch[i] <= ce[i];
                    count_latched[i] <= 1'b1;
                end
            end
            if (rb_status[i] && !status_latched[i]) begin
                status_latch[i] <= status_now[i];
                status_latched[i] <= 1'b1;
            end
            if (cnt_read[i]) begin
                if (status_latched[i]) begin
                    status_latched[i] <= 1'b0;
                end else begin
                    read_msb[i] <= ctrl[i][5:4] == FMT_BOTH && !read_msb[i];
                    if (ctrl[i][5:4] != FMT_BOTH || read_msb[i]) begin
                        count_latched[i] <= 1'b0;
                    end
                end
            end
            if (cw_hit[i]) begin
                ctrl[i] <= wr_data[5:0];
                null_count[i] <= 1'b1;
                out[i] <= wr_data[3:1] != MODE_TERMINAL;
                running[i] <= 1'b0;
                load_req[i] <= 1'b0;
                trig[i] <= 1'b0;
                write_msb[i] <= 1'b0;
                read_msb[i] <= 1'b0;
                count_latched[i] <= 1'b0;
                status_latched[i] <= 1'b0;
            end
        end
        if (rst_i) begin
            for (int i = 0; i < NUM_COUNTERS; i++) begin
                ctrl[i] <= CTRL_RESET;
                cr[i] <= 16'h0000;
                cr_lo_stage[i] <= 8'h00;
                ce[i] <= 16'h0000;
                read_latch[i] <= 16'h0000;
                status_latch[i] <= 8'h00;
            end
            count_latched <= 3'h0;
            status_latched <= 3'h0;
            null_count <= 3'h7;
            write_msb <= 3'h0;
            read_msb <= 3'h0;
            load_req <= 3'h0;
            trig <= 3'h0;
            running <= 3'h0;
            out <= 3'h0;
        end
    end
endmodule : interval_timer

// ===== dv/interval_timer_properties.sv
// Concurrent checks on the interval timer top-level ports.
// Assumes count clocks whose half period is at least four reference clocks.
`timescale 1ns/100ps
module interval_timer_properties (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic port_select_lo_i,
    input wire logic port_select_hi_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] data_i,
    input wire logic [7:0] data_o,
    input wire logic data_oe_o,
    input wire logic [interval_timer_pkg::NUM_COUNTERS-1:0] count_clk_i,
    input wire logic [interval_timer_pkg::NUM_COUNTERS-1:0] gate_i,
    input wire logic [interval_timer_pkg::NUM_COUNTERS-1:0] out_o
);
    import interval_timer_pkg::*;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic clk0_q;
    logic out0_q;
    logic low_seen;
    logic [3:0] since_fall;
    logic [2:0] low_falls;
    wire clk0_fell = clk0_q && !count_clk_i[0];
    wire out0_fell = out0_q && !out_o[0];
    wire [1:0] port_sel = {port_select_hi_i, port_select_lo_i};
    // Tracks count clock falls seen while counter 0 output is low.
    always_ff @(posedge ref_clk_i) begin
        clk0_q <= count_clk_i[0];
        out0_q <= out_o[0];
        if (rst_i) begin
            since_fall <= 4'hF;
            low_falls <= 3'h0;
            low_seen <= 1'b0;
        end else begin
            since_fall <= clk0_fell ? 4'h0 : since_fall + {3'h0, since_fall != 4'hF};
            if (out0_fell) begin
                low_falls <= 3'h0;
                low_seen <= 1'b1;
            end else if (clk0_fell && low_falls != 3'h7) begin
                low_falls <= low_falls + 3'h1;
            end
        end
    end
    sequence ctrl_read_s;
        (!cs_n_i && !rd_n_i && port_sel == PORT_CONTROL) [*3];
    endsequence
    sequence data_read_s;
        (!cs_n_i && !rd_n_i && port_sel != PORT_CONTROL) [*3];
    endsequence
    sequence strobe_low_s;
        (!out_o[0]) [*4] ##[1:40] out_o[0];
    endsequence
    reset_idle_a: assert property (disable iff (1'b0) rst_i |=> out_o == '0 && !data_oe_o)
        else $error("outputs not idle after reset");
    ctrl_read_quiet_a: assert property (ctrl_read_s |-> !data_oe_o)
        else $error("control port read drove the bus");
    data_read_drive_a: assert property (data_read_s |-> data_oe_o)
        else $error("data port read left the bus undriven");
    deselect_quiet_a: assert property (cs_n_i [*3] |-> !data_oe_o)
        else $error("bus driven while deselected");
    read_release_a: assert property (rd_n_i [*3] |-> !data_oe_o)
        else $error("bus driven without read strobe");
    strobe_width_a: assert property ($fell(out_o[0]) |=> strobe_low_s)
        else $error("strobe width wrong");
    strobe_cause_a: assert property ($fell(out_o[0]) |-> since_fall <= 4'h5)
        else $error("strobe fell without a count clock");
    strobe_single_a: assert property ($rose(out_o[0]) && low_seen |-> low_falls == 3'h1)
        else $error("strobe low for other than one count clock");
endmodule : interval_timer_properties

bind interval_timer interval_timer_properties u_props (.ref_clk_i, .rst_i, .cs_n_i,
    .port_select_lo_i, .port_select_hi_i, .rd_n_i, .wr_n_i, .data_i, .data_o, .data_oe_o,
    .count_clk_i, .gate_i, .out_o);

// ===== dv/bus_host_model.sv
// Processor-side model of the timer's parallel bus.
// Assumes the caller freezes count clocks around direct reads.
`timescale 1ns/100ps
module bus_host_model (
    input wire logic ref_clk_i,
    input wire logic [7:0] data_o,
    output logic cs_n_o = 1'b1,
    output logic port_select_lo_o = 1'b0,
    output logic port_select_hi_o = 1'b0,
    output logic rd_n_o = 1'b1,
    output logic wr_n_o = 1'b1,
    output logic [7:0] wr_data_o = 8'h00
);
    // Control port writes carry both read-back and mode words.
    task automatic write_port(input logic [1:0] port, input logic [7:0] val);
        @(posedge ref_clk_i);
        #5 {port_select_hi_o, port_select_lo_o} = port;
        wr_data_o = val;
        cs_n_o = 1'b0;
        wr_n_o = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #5 cs_n_o = 1'b1;
        wr_n_o = 1'b1;
        wr_data_o = ~val;
        repeat (4) @(posedge ref_clk_i);
    endtask : write_port
    // Unlatched reads are only issued with the count clock held still.
    task automatic read_port(input logic [1:0] port, output logic [7:0] val);
        @(posedge ref_clk_i);
        #5 {port_select_hi_o, port_select_lo_o} = port;
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        repeat (5) @(posedge ref_clk_i);
        val = data_o;
        #5 cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        repeat (4) @(posedge ref_clk_i);
    endtask : read_port
endmodule : bus_host_model

// ===== dv/test_interval_timer.sv
// Self-checking bench for the interval timer, counters 0 and 1 in strobe mode, counter 2 in square-wave mode.
// Assumes the bus host model and the bound port checker.
`timescale 1ns/100ps
module test_interval_timer;
    import interval_timer_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [NUM_COUNTERS-1:0] count_clk = '1;
    logic [NUM_COUNTERS-1:0] gate = '0;
    wire cs_n, psel_lo, psel_hi, rd_n, wr_n, rdata_oe;
    wire [7:0] wdata, rdata;
    wire [NUM_COUNTERS-1:0] out;
    int miscompares = 0;
    int checks_done = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    bus_host_model host (.ref_clk_i, .data_o(rdata), .cs_n_o(cs_n), .port_select_lo_o(psel_lo),
        .port_select_hi_o(psel_hi), .rd_n_o(rd_n), .wr_n_o(wr_n), .wr_data_o(wdata));
    interval_timer DUT (.ref_clk_i, .rst_i, .cs_n_i(cs_n), .port_select_lo_i(psel_lo),
        .port_select_hi_i(psel_hi), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(wdata),
        .data_o(rdata), .data_oe_o(rdata_oe), .count_clk_i(count_clk), .gate_i(gate),
        .out_o(out));
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_byte
    task automatic check_pin(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t pin %b expected %b", $time, got, exp);
        end
    endtask : check_pin
    task automatic set_gate(input int ch, input logic level);
        @(posedge ref_clk_i);
        #5 gate[ch] = level;
        repeat (4) @(posedge ref_clk_i);
    endtask : set_gate
    task automatic expect_read(input logic [1:0] port, input logic [7:0] exp);
        logic [7:0] val;
        host.read_port(port, val);
        check_byte(val, exp);
    endtask : expect_read
    task automatic tick(input int n, input int ch = 0);
        repeat (n) begin
            @(posedge ref_clk_i);
            #5 count_clk[ch] = 1'b0;
            repeat (4) @(posedge ref_clk_i);
            #5 count_clk[ch] = 1'b1;
            repeat (4) @(posedge ref_clk_i);
        end
    endtask : tick
    task automatic trigger;
        @(posedge ref_clk_i);
        #5 gate[0] = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #5 gate[0] = 1'b1;
        repeat (4) @(posedge ref_clk_i);
    endtask : trigger
    task automatic test_strobe;
        host.write_port(PORT_CONTROL, 8'h3A);
        host.write_port(2'h0, 8'h03);
        host.write_port(2'h0, 8'h00);
        tick(4);
        check_pin(out[0], 1'b1);
        trigger();
        tick(2);
        trigger();
        for (int i = 1; i <= 5; i++) begin
            tick(1);
            check_pin(out[0], i != 4);
        end
        $display("strobe test done");
    endtask : test_strobe
    task automatic test_status;
        host.write_port(PORT_CONTROL, 8'hE2);
        expect_read(2'h0, 8'hBA);
        host.write_port(2'h0, 8'h10);
        host.write_port(2'h0, 8'h00);
        host.write_port(PORT_CONTROL, 8'hE2);
        expect_read(2'h0, 8'hFA);
        $display("status test done");
    endtask : test_status
    task automatic test_latch;
        trigger();
        tick(3);
        host.write_port(PORT_CONTROL, 8'h00);
        tick(2);
        host.write_port(PORT_CONTROL, 8'h00);
        expect_read(2'h0, 8'h0E);
        host.write_port(2'h0, 8'h05);
        expect_read(2'h0, 8'h00);
        host.write_port(2'h0, 8'h00);
        host.write_port(PORT_CONTROL, 8'hC2);
        expect_read(2'h0, 8'hFA);
        expect_read(2'h0, 8'h0C);
        expect_read(2'h0, 8'h00);
        tick(1);
        expect_read(2'h0, 8'h0B);
        expect_read(2'h0, 8'h00);
        $display("latch test done");
    endtask : test_latch
    task automatic test_multi;
        host.write_port(PORT_CONTROL, 8'h7A);
        host.write_port(2'h1, 8'h07);
        host.write_port(2'h1, 8'h00);
        host.write_port(PORT_CONTROL, 8'hE3);
        expect_read(2'h0, 8'h0B);
        expect_read(2'h0, 8'h00);
        host.write_port(PORT_CONTROL, 8'hE6);
        expect_read(2'h1, 8'hFA);
        trigger();
        tick(1);
        host.write_port(PORT_CONTROL, 8'hE2);
        expect_read(2'h0, 8'hFA);
        host.write_port(PORT_CONTROL, 8'hE2);
        expect_read(2'h0, 8'hBA);
        $display("multi test done");
    endtask : test_multi
    // Counter 2 in square-wave mode through the aliased mode code 7, gate held low at first.
    task automatic test_square;
        host.write_port(PORT_CONTROL, 8'hBE);
        host.write_port(2'h2, 8'h08);
        host.write_port(2'h2, 8'h00);
        tick(3, 2);
        expect_read(2'h2, 8'h08);
        expect_read(2'h2, 8'h00);
        set_gate(2, 1'b1);
        tick(2, 2);
        expect_read(2'h2, 8'h06);
        expect_read(2'h2, 8'h00);
        tick(3, 2);
        check_pin(out[2], 1'b0);
        set_gate(2, 1'b0);
        check_pin(out[2], 1'b1);
        $display("square test done");
    endtask : test_square
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        miscompares++;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge ref_clk_i);
        #5 rst_i = 1'b0;
        test_strobe();
        test_status();
        test_latch();
        test_multi();
        test_square();
        report_and_stop();
    end
endmodule : test_interval_timer
